// ===== hw/froe_alu.sv
// Increment / decrement unit with zero detect
`timescale 1ns/1ps
module froe_alu
  import froe_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // Operand and decrement select
  input wire logic [WIDTH-1:0] a_i,
  input wire logic dec_i,
  // Result
  output logic [WIDTH-1:0] y_o,
  output logic zero_o
);
  if (WIDTH < 1) begin : g_width_check
    $error("froe_alu: WIDTH must be at least 1");
  end
  // Wraps modulo 2^WIDTH, no carry out [RULE9]
  assign y_o = dec_i ? WIDTH'(a_i - 1'b1) : WIDTH'(a_i + 1'b1);
  assign zero_o = (y_o == '0); // [RULE8]
endmodule

// ===== hw/froe_core.sv
// File register op executor: clear, inc/dec, skip and branch
// How it works
// [RULE1] A clear-file op writes zero to the file register at the 7-bit address and sets zero.
// [RULE2] A clear-working op writes zero to the working register and sets zero, no operand.
// [RULE3] A decrement op writes f-1 to working (dest 0) or file (dest 1) and updates zero.
// [RULE4] An increment op writes f+1 to working (dest 0) or file (dest 1) and updates zero.
// [RULE5] Decrement-skip writes f-1 to the destination, flags untouched, and flushes next if 0.
// [RULE6] A branch loads its 11-bit literal into count<10:0> and latch<4:3> into count<12:11>.
// [RULE7] A branch always takes two cycles, the second one an empty slot.
// [RULE8] Inc and dec set zero when the 8-bit result is zero and clear it otherwise.
// [RULE9] Inc and dec wrap modulo 256 and touch no carry or borrow flag.
`timescale 1ns/1ps
module froe_core
  import froe_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Decoded instruction
  input wire logic op_valid_i,
  input wire froe_op_t op_i,
  input wire logic [FADDR_W-1:0] faddr_i,
  input wire logic dest_i,
  input wire logic [LIT_W-1:0] lit_i,
  // Core state inputs
  input wire logic [DATA_W-1:0] fdata_i,
  input wire logic [PAGE_W-1:0] page_latch_i,
  // File register write port
  output logic fwr_en_o,
  output logic [FADDR_W-1:0] fwr_addr_o,
  output logic [DATA_W-1:0] fwr_data_o,
  // Core state outputs
  output logic [DATA_W-1:0] working_o,
  output logic zero_flag_o,
  output logic [PROG_CNT_W-1:0] program_counter_o,
  output logic flush_o
);
  froe_state_t state_q;
  logic [DATA_W-1:0] alu_y;
  logic alu_z;
  logic take;
  logic is_dec;

  assign take = op_valid_i && (state_q == FROE_ST_RUN);
  assign is_dec = (op_i == FROE_OP_DEC) || (op_i == FROE_OP_DSZ);

  froe_alu #(
    .WIDTH(DATA_W)
  ) u_alu (
    .a_i(fdata_i),
    .dec_i(is_dec),
    .y_o(alu_y),
    .zero_o(alu_z)
  );

  // Sequencer for the empty slot
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= FROE_ST_RUN;
      flush_o <= 1'b0;
    end else begin
      case (state_q)
        FROE_ST_RUN: begin
          if (take && (op_i == FROE_OP_BR)) begin
            state_q <= FROE_ST_FLUSH; // [RULE7]
            flush_o <= 1'b1;
          end else if (take && (op_i == FROE_OP_DSZ) && alu_z) begin
            state_q <= FROE_ST_FLUSH; // [RULE5]
            flush_o <= 1'b1;
          end else begin
            flush_o <= 1'b0;
          end
        end
        FROE_ST_FLUSH: begin
          state_q <= FROE_ST_RUN;
          flush_o <= 1'b0;
        end
        default: begin
          state_q <= FROE_ST_RUN;
          flush_o <= 1'b0;
        end
      endcase
    end
  end

  // File register write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwr_en_o <= 1'b0;
      fwr_addr_o <= '0;
      fwr_data_o <= ZERO_B;
    end else begin
      fwr_en_o <= 1'b0;
      fwr_addr_o <= faddr_i;
      fwr_data_o <= alu_y;
      if (take) begin
        case (op_i)
          FROE_OP_CLEAR_FILE: begin
            fwr_en_o <= 1'b1; // [RULE1]
            fwr_data_o <= ZERO_B;
          end
          FROE_OP_DEC, FROE_OP_INC, FROE_OP_DSZ: begin
            fwr_en_o <= (dest_i == DEST_F); // [RULE3] [RULE4] [RULE5]
          end
          default: begin
            fwr_en_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Working register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      working_o <= W_RST;
    end else if (take) begin
      case (op_i)
        FROE_OP_CLEAR_WORK: working_o <= ZERO_B; // [RULE2]
        FROE_OP_DEC, FROE_OP_INC, FROE_OP_DSZ: begin
          if (dest_i == DEST_W) begin
            working_o <= alu_y; // [RULE3] [RULE4] [RULE5]
          end
        end
        default: working_o <= working_o;
      endcase
    end
  end

  // Zero flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_flag_o <= 1'b0;
    end else if (take) begin
      case (op_i)
        FROE_OP_CLEAR_FILE: zero_flag_o <= 1'b1; // [RULE1]
        FROE_OP_CLEAR_WORK: zero_flag_o <= 1'b1; // [RULE2]
        FROE_OP_DEC, FROE_OP_INC: zero_flag_o <= alu_z; // [RULE8]
        default: zero_flag_o <= zero_flag_o; // [RULE5] [RULE6]
      endcase
    end
  end

  // Program counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_counter_o <= PROG_CNT_RST;
    end else if (take && (op_i == FROE_OP_BR)) begin
      program_counter_o <= {page_latch_i[PAGE_HI:PAGE_LO], lit_i}; // [RULE6]
    end else begin
      program_counter_o <= PROG_CNT_W'(program_counter_o + PROG_CNT_ONE);
    end
  end

  // Checks
  a_clear_file_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
    take && op_i == FROE_OP_CLEAR_FILE |=> fwr_en_o && fwr_data_o == ZERO_B && zero_flag_o)
    else $error("clear-file did not clear and set zero");
  a_clear_work_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE2]
    take && op_i == FROE_OP_CLEAR_WORK |=> working_o == ZERO_B && zero_flag_o && !fwr_en_o)
    else $error("clear-working did not clear and set zero");
  a_dec_dest_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
    take && op_i == FROE_OP_DEC && dest_i == DEST_W |=>
      working_o == DATA_W'($past(fdata_i) - ONE_B) && !fwr_en_o)
    else $error("decrement to working wrong");
  a_inc_file_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
    take && op_i == FROE_OP_INC && dest_i == DEST_F |=>
      fwr_en_o && fwr_data_o == DATA_W'($past(fdata_i) + ONE_B))
    else $error("increment to file wrong");
  a_dsz_skip_flush: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
    take && op_i == FROE_OP_DSZ |=>
      flush_o == ($past(fdata_i) == ONE_B) && $stable(zero_flag_o))
    else $error("decrement-skip flush or flag wrong");
  a_branch_pc_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE6]
    take && op_i == FROE_OP_BR |=>
      program_counter_o == {$past(page_latch_i[PAGE_HI:PAGE_LO]), $past(lit_i)}
      && $stable(zero_flag_o))
    else $error("branch target wrong");
  a_branch_two_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
    take && op_i == FROE_OP_BR |=> flush_o ##1 !flush_o && state_q == FROE_ST_RUN)
    else $error("branch not two cycles");
  a_zero_tracks_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE8]
    take && (op_i == FROE_OP_INC || op_i == FROE_OP_DEC) |=> zero_flag_o == (
      $past(op_i) == FROE_OP_INC ? $past(fdata_i) == 8'hff : $past(fdata_i) == ONE_B))
    else $error("zero flag does not match result");
  a_wrap_inc_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE9]
    take && op_i == FROE_OP_INC && dest_i == DEST_W && fdata_i == 8'hff |=>
      working_o == ZERO_B)
    else $error("increment did not wrap");
  a_clear_file_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
    take && op_i == FROE_OP_CLEAR_FILE |=>
      fwr_addr_o == $past(faddr_i))
    else $error("clear-file wrote the wrong address");
  a_dec_file_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
    take && op_i == FROE_OP_DEC && dest_i == DEST_F |=>
      fwr_en_o && fwr_data_o == DATA_W'($past(fdata_i) - ONE_B) && $stable(working_o))
    else $error("decrement to file wrong");
  a_inc_dest_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
    take && op_i == FROE_OP_INC && dest_i == DEST_W |=>
      working_o == DATA_W'($past(fdata_i) + ONE_B) && !fwr_en_o)
    else $error("increment to working wrong");
  a_dsz_dest_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
    take && op_i == FROE_OP_DSZ |=>
      fwr_en_o == ($past(dest_i) == DEST_F) && fwr_data_o == DATA_W'($past(fdata_i) - ONE_B))
    else $error("decrement-skip file write wrong");
  a_dsz_work_dest: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
    take && op_i == FROE_OP_DSZ && dest_i == DEST_W |=>
      working_o == DATA_W'($past(fdata_i) - ONE_B))
    else $error("decrement-skip to working wrong");
  a_slot_no_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
    state_q == FROE_ST_FLUSH |=>
      !fwr_en_o && !flush_o && $stable(working_o) && $stable(zero_flag_o))
    else $error("discarded slot changed state");
  a_branch_no_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE6]
    take && op_i == FROE_OP_BR |=>
      !fwr_en_o && $stable(working_o))
    else $error("branch touched file or working register");
  a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
    !(take && op_i == FROE_OP_BR) |=>
      program_counter_o == PROG_CNT_W'($past(program_counter_o) + PROG_CNT_ONE))
    else $error("program counter did not step");
  a_wrap_dec_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE9]
    take && op_i == FROE_OP_DEC && dest_i == DEST_W && fdata_i == ZERO_B |=>
      working_o == ~ZERO_B && !zero_flag_o)
    else $error("decrement did not wrap");
endmodule

// ===== hw/froe_pkg.sv
// Constants and types for the file register op executor
package froe_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PROG_CNT_W = 13;
  localparam int LIT_W = 11;
  localparam int PAGE_W = 5;
  localparam int PAGE_LO = 3;
  localparam int PAGE_HI = 4;
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_RST = 13'h0000;
  localparam logic [DATA_W-1:0] W_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_B = 8'h00;
  localparam logic [DATA_W-1:0] ONE_B = 8'h01;
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_ONE = 13'h0001;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;

  typedef enum logic [2:0] {
    FROE_OP_NONE = 3'h0,
    FROE_OP_CLEAR_FILE = 3'h1,
    FROE_OP_CLEAR_WORK = 3'h2,
    FROE_OP_DEC = 3'h3,
    FROE_OP_INC = 3'h4,
    FROE_OP_DSZ = 3'h5,
    FROE_OP_BR = 3'h6
  } froe_op_t;

  typedef enum logic [1:0] {
    FROE_ST_RUN = 2'b00,
    FROE_ST_FLUSH = 2'b01
  } froe_state_t;
endpackage

// ===== verification/tb_top.sv
// Self-checking bench for the file register op executor
`timescale 1ns/1ps
module tb_top;
  import froe_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  froe_op_t op_i = FROE_OP_NONE;
  logic [FADDR_W-1:0] faddr_i = 7'h00;
  logic dest_i = 1'b0;
  logic [LIT_W-1:0] lit_i = 11'h000;
  logic [DATA_W-1:0] fdata_i = 8'h00;
  logic [PAGE_W-1:0] page_latch_i = 5'h00;
  logic fwr_en_o;
  logic [FADDR_W-1:0] fwr_addr_o;
  logic [DATA_W-1:0] fwr_data_o;
  logic [DATA_W-1:0] working_o;
  logic zero_flag_o;
  logic [PROG_CNT_W-1:0] program_counter_o;
  logic flush_o;
  int bad_count = 0;
  int cmp_count = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  froe_core dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .op_valid_i(op_valid_i),
    .op_i(op_i),
    .faddr_i(faddr_i),
    .dest_i(dest_i),
    .lit_i(lit_i),
    .fdata_i(fdata_i),
    .page_latch_i(page_latch_i),
    .fwr_en_o(fwr_en_o),
    .fwr_addr_o(fwr_addr_o),
    .fwr_data_o(fwr_data_o),
    .working_o(working_o),
    .zero_flag_o(zero_flag_o),
    .program_counter_o(program_counter_o),
    .flush_o(flush_o)
  );

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One op presented at the next edge, taken unless in the empty slot, outputs settled on return
  task automatic run(input froe_op_t o, input logic [6:0] a, input logic d,
                     input logic [7:0] f, input logic [10:0] l, input logic [4:0] p);
    @(negedge ref_clk_i);
    op_valid_i = 1'b1;
    op_i = o;
    faddr_i = a;
    dest_i = d;
    fdata_i = f;
    lit_i = l;
    page_latch_i = p;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic s_clear();
    run(FROE_OP_INC, 7'h05, DEST_W, 8'h7f, 11'h000, 5'h00);
    chk({working_o, zero_flag_o}, {8'h80, 1'b0});
    run(FROE_OP_CLEAR_WORK, 7'h00, DEST_W, 8'h00, 11'h000, 5'h00);
    chk({working_o, zero_flag_o}, {8'h00, 1'b1});
    run(FROE_OP_INC, 7'h05, DEST_W, 8'h7f, 11'h000, 5'h00);
    run(FROE_OP_CLEAR_FILE, 7'h7f, DEST_W, 8'h5a, 11'h000, 5'h00);
    chk({fwr_en_o, fwr_addr_o, fwr_data_o}, {1'b1, 7'h7f, 8'h00});
    chk({working_o, zero_flag_o}, {8'h80, 1'b1});
  endtask

  task automatic s_incdec();
    run(FROE_OP_INC, 7'h11, DEST_F, 8'hff, 11'h000, 5'h00);
    chk({fwr_en_o, fwr_addr_o, fwr_data_o, zero_flag_o}, {1'b1, 7'h11, 8'h00, 1'b1});
    run(FROE_OP_DEC, 7'h12, DEST_W, 8'h00, 11'h000, 5'h00);
    chk({working_o, fwr_en_o, zero_flag_o}, {8'hff, 2'b00});
    run(FROE_OP_INC, 7'h14, DEST_W, 8'hff, 11'h000, 5'h00);
    chk({working_o, fwr_en_o, zero_flag_o}, {8'h00, 2'b01});
    run(FROE_OP_DEC, 7'h13, DEST_F, 8'h01, 11'h000, 5'h00);
    chk({fwr_en_o, fwr_addr_o, fwr_data_o, zero_flag_o}, {1'b1, 7'h13, 8'h00, 1'b1});
  endtask

  task automatic s_skip();
    run(FROE_OP_DSZ, 7'h20, DEST_F, 8'h03, 11'h000, 5'h00);
    chk({fwr_en_o, fwr_data_o, flush_o, zero_flag_o}, {1'b1, 8'h02, 2'b01});
    run(FROE_OP_DSZ, 7'h21, DEST_W, 8'h01, 11'h000, 5'h00);
    chk({working_o, flush_o, zero_flag_o, fwr_en_o}, {8'h00, 3'b110});
    run(FROE_OP_INC, 7'h22, DEST_F, 8'h40, 11'h000, 5'h00);
    chk({working_o, flush_o, fwr_en_o}, {8'h00, 2'b00});
  endtask

  task automatic s_branch();
    run(FROE_OP_DEC, 7'h30, DEST_W, 8'h00, 11'h000, 5'h00);
    run(FROE_OP_BR, 7'h00, DEST_W, 8'h00, 11'h7ff, 5'h1f);
    chk({program_counter_o, flush_o, zero_flag_o}, {13'h1fff, 2'b10});
    run(FROE_OP_CLEAR_WORK, 7'h00, DEST_W, 8'h00, 11'h000, 5'h00);
    chk({working_o, program_counter_o, flush_o}, {8'hff, 13'h0000, 1'b0});
    run(FROE_OP_BR, 7'h00, DEST_W, 8'h00, 11'h000, 5'h0f);
    chk({program_counter_o, flush_o}, {13'h0800, 1'b1});
    @(negedge ref_clk_i);
    op_valid_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk({program_counter_o, flush_o, working_o}, {13'h0801, 1'b0, 8'hff});
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    s_clear();
    s_incdec();
    s_skip();
    s_branch();
    conclude();
  end

  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule
